/* File: shared/cwm_regs.svh */
// Register offsets, field positions, reset values and timing constants
`ifndef CWM_REGS_SVH
`define CWM_REGS_SVH
`define CWM_ADDR_W          8
`define CWM_DATA_W          24
`define CWM_ADDR_CAL        8'h12
`define CWM_ADDR_EMUX       8'h14
// Calibration source configuration fields
`define CWM_CAL_EN_BIT      22
`define CWM_CAL_MODE_BIT    21
`define CWM_CAL_AMP_BIT     20
`define CWM_CAL_FREQ_HI     14
`define CWM_CAL_FREQ_LO     12
`define CWM_CAL_HALF_BIT    11
`define CWM_CAL_HIGH_HI     10
`define CWM_CAL_HIGH_LO     0
`define CWM_CAL_MASK        24'h707fff
`define CWM_CAL_RESET       24'h004800
// Input multiplexer configuration fields
`define CWM_MUX_INV_BIT     23
`define CWM_MUX_PISO_BIT    21
`define CWM_MUX_NISO_BIT    20
`define CWM_MUX_PRT_HI      19
`define CWM_MUX_PRT_LO      18
`define CWM_MUX_NRT_HI      17
`define CWM_MUX_NRT_LO      16
`define CWM_MUX_MASK        24'hbf0000
`define CWM_MUX_RESET       24'h300000
// Divider exponents of the calibration frequency codes
`define CWM_FSH_0           7
`define CWM_FSH_1           9
`define CWM_FSH_2           11
`define CWM_FSH_3           13
`define CWM_FSH_4           15
`define CWM_FSH_5           17
`define CWM_FSH_6           19
`define CWM_FSH_7           21
// System clock and master tick generation
`define CWM_CLK_HZ          50000000
`define CWM_MSTR_HZ_0       32768.0
`define CWM_MSTR_HZ_1       32000.0
`define CWM_MSTR_HZ_3       31968.78
`define CWM_ACC_W           32
`endif

/* File: shared/cwm_pkg.sv */
// Types shared by the calibration wave and input mux block
package cwm_pkg;
  typedef enum logic [1:0] {
    CWM_ROUTE_NONE = 2'h0,
    CWM_ROUTE_MID  = 2'h1,
    CWM_ROUTE_SRCP = 2'h2,
    CWM_ROUTE_SRCN = 2'h3
  } cwm_route_t;

  typedef struct packed {
    logic enable;
    logic bipolar;
    logic amp_double;
    logic phase_high;
  } cwm_cal_out_t;

  typedef struct packed {
    logic       invert;
    logic       pos_connect;
    logic       neg_connect;
    cwm_route_t pos_route;
    cwm_route_t neg_route;
  } cwm_mux_out_t;
endpackage : cwm_pkg

/* File: verilog/cwm_top.sv */
// Calibration square-wave timing and input multiplexer control
// Functional notes
// RL1: One enable bit switches both calibration sources and their modes, reset off.
// RL2: The swing bit picks unipolar (mid plus magnitude to mid) or bipolar (plus to minus).
// RL3: The amplitude bit picks the small step when clear and double that when set.
// RL4: A three-bit code divides the master clock by 2^7..2^13 step 2, then 2^15..2^21, reset 100.
// RL5: Waveform timing follows the selected master clock; the period is one over the frequency.
// RL6: With half duty selected, the default, the wave is high half of each period.
// RL7: Otherwise the high part lasts the eleven-bit high-time value in time steps, reset zero.
// RL8: The time step comes from the master clock; about 30.52 us at the 32768 Hz setting.
// RL9: The polarity bit passes the input straight when clear and inverted when set.
// RL10: The positive isolate bit connects the positive input when clear, reset isolated.
// RL11: The negative isolate bit connects the negative input when clear, reset isolated.
// RL12: Each input has a two-bit route: none, mid reference, positive or negative source.
// RL13: Routing a calibration source to an input works only while calibration is enabled.
// RL14: Calibration sources can be routed through the input muxes for end-to-end tests.
// RL15: Software should isolate an input before driving a source while electrodes are on.
// RL16: The master selection sets the time step: 30.52, 31.25, 31.25 and 31.28 us.
// RL17: A free-running master-clock counter makes the wave, high from period start.
//
// The address-and-strobe port is this design's own decision.
`timescale 1ns/100ps
`include "cwm_regs.svh"

module cwm_top (
  input  wire logic                      clock,
  input  wire logic                      rst_b,
  input  wire logic [`CWM_ADDR_W-1:0]    reg_addr,
  input  wire logic [`CWM_DATA_W-1:0]    reg_wdata,
  input  wire logic                      reg_wr,
  input  wire logic                      reg_rd,
  output logic      [`CWM_DATA_W-1:0]    reg_rdata,
  input  wire logic [1:0]                master_freq_select,
  output logic                           master_tick,
  output cwm_pkg::cwm_cal_out_t          cal_out,
  output cwm_pkg::cwm_mux_out_t          mux_out
);

  localparam int ACC_W = `CWM_ACC_W;
  localparam int CNT_W = `CWM_FSH_7;

  // Phase increments for each master clock setting
  localparam logic [ACC_W-1:0] INC_0 =
    ACC_W'(longint'(`CWM_MSTR_HZ_0 * 4294967296.0 / `CWM_CLK_HZ + 0.5));
  localparam logic [ACC_W-1:0] INC_1 =
    ACC_W'(longint'(`CWM_MSTR_HZ_1 * 4294967296.0 / `CWM_CLK_HZ + 0.5));
  localparam logic [ACC_W-1:0] INC_3 =
    ACC_W'(longint'(`CWM_MSTR_HZ_3 * 4294967296.0 / `CWM_CLK_HZ + 0.5));

  logic [`CWM_DATA_W-1:0] cal_cfg_reg;
  logic [`CWM_DATA_W-1:0] mux_cfg_reg;
  logic [ACC_W-1:0]       acc_reg;
  logic [ACC_W-1:0]       inc;
  logic [ACC_W:0]         acc_sum;
  logic                   tick_reg;
  logic [CNT_W-1:0]       cnt_reg;
  logic [CNT_W-1:0]       cnt_next;
  logic [CNT_W:0]         period_len;
  logic [CNT_W:0]         last_cnt;
  logic [CNT_W:0]         high_len;
  logic                   phase_next;
  logic                   phase_reg;

  // Configuration fields
  logic        cal_source_enable;
  logic        cal_swing_mode;
  logic        cal_amplitude_select;
  logic [2:0]  cal_freq_select;
  logic        half_duty_select;
  logic [10:0] cal_high_time;

  assign cal_source_enable    = cal_cfg_reg[`CWM_CAL_EN_BIT];
  assign cal_swing_mode       = cal_cfg_reg[`CWM_CAL_MODE_BIT];
  assign cal_amplitude_select = cal_cfg_reg[`CWM_CAL_AMP_BIT];
  assign cal_freq_select      = cal_cfg_reg[`CWM_CAL_FREQ_HI:`CWM_CAL_FREQ_LO];
  assign half_duty_select     = cal_cfg_reg[`CWM_CAL_HALF_BIT];
  assign cal_high_time        = cal_cfg_reg[`CWM_CAL_HIGH_HI:`CWM_CAL_HIGH_LO];

  // Calibration configuration register, reserved bits held at zero
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      cal_cfg_reg <= `CWM_CAL_RESET; // RL1 RL4 RL6 RL7
    end else if (reg_wr && reg_addr == `CWM_ADDR_CAL) begin
      cal_cfg_reg <= reg_wdata & `CWM_CAL_MASK;
    end
  end

  // Input multiplexer configuration register
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      mux_cfg_reg <= `CWM_MUX_RESET; // RL9 RL10 RL11 RL12
    end else if (reg_wr && reg_addr == `CWM_ADDR_EMUX) begin
      mux_cfg_reg <= reg_wdata & `CWM_MUX_MASK;
    end
  end

  // Read data, valid only in the cycle after the strobe
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      case (reg_addr)
        `CWM_ADDR_CAL:  reg_rdata <= cal_cfg_reg;
        `CWM_ADDR_EMUX: reg_rdata <= mux_cfg_reg;
        default:        reg_rdata <= '0; // Unmapped reads as zero
      endcase
    end else begin
      reg_rdata <= '0;
    end
  end

  // Increment picked by the master clock selection
  always_comb begin
    case (master_freq_select)
      2'h0:    inc = INC_0; // RL5 RL16
      2'h1:    inc = INC_1; // RL16
      2'h2:    inc = INC_1; // RL16
      default: inc = INC_3; // RL16
    endcase
  end

  assign acc_sum = {1'b0, acc_reg} + {1'b0, inc};

  // Fractional accumulator; a carry is one master clock period
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      acc_reg <= '0;
    end else begin
      acc_reg <= acc_sum[ACC_W-1:0]; // RL5
    end
  end

  // One-cycle master tick, also brought out for observation
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      tick_reg <= 1'b0;
    end else begin
      tick_reg <= acc_sum[ACC_W]; // RL8 RL16
    end
  end

  assign master_tick = tick_reg;

  // Period length in master ticks for the frequency code
  always_comb begin
    period_len = '0;
    case (cal_freq_select)
      3'h0:    period_len[`CWM_FSH_0] = 1'b1; // RL4
      3'h1:    period_len[`CWM_FSH_1] = 1'b1; // RL4
      3'h2:    period_len[`CWM_FSH_2] = 1'b1; // RL4
      3'h3:    period_len[`CWM_FSH_3] = 1'b1; // RL4
      3'h4:    period_len[`CWM_FSH_4] = 1'b1; // RL4
      3'h5:    period_len[`CWM_FSH_5] = 1'b1; // RL4
      3'h6:    period_len[`CWM_FSH_6] = 1'b1; // RL4
      default: period_len[`CWM_FSH_7] = 1'b1; // RL4
    endcase
  end

  assign last_cnt = period_len - (CNT_W+1)'(1);

  // High time: half the period, or the programmed steps of one tick
  assign high_len = half_duty_select ? (period_len >> 1) // RL6
                                     : (CNT_W+1)'(cal_high_time); // RL7 RL8

  // Counter wraps at period end; a shortened period wraps on the next master tick
  always_comb begin
    cnt_next = cnt_reg;
    if (!cal_source_enable) begin
      cnt_next = '0; // RL1
    end else if (tick_reg) begin
      if ({1'b0, cnt_reg} >= last_cnt) begin
        cnt_next = '0; // RL17
      end else begin
        cnt_next = cnt_reg + CNT_W'(1); // RL17
      end
    end
  end

  // Free-running period counter on master ticks
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_next; // RL17
    end
  end

  // High from period start until the high count is reached
  assign phase_next = cal_source_enable && ({1'b0, cnt_reg} < high_len); // RL1 RL17

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      phase_reg <= 1'b0;
    end else begin
      phase_reg <= phase_next;
    end
  end

  // Source control outputs for the analog generators
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      cal_out <= '0;
    end else begin
      cal_out.enable     <= cal_source_enable; // RL1
      cal_out.bipolar    <= cal_source_enable & cal_swing_mode; // RL2
      cal_out.amp_double <= cal_source_enable & cal_amplitude_select; // RL3
      cal_out.phase_high <= phase_reg & cal_source_enable; // RL1
    end
  end

  // Per-input route gating: source routes fall back to none when disabled
  logic [1:0] route_raw [2];
  logic [1:0] route_eff [2];

  assign route_raw[0] = mux_cfg_reg[`CWM_MUX_PRT_HI:`CWM_MUX_PRT_LO];
  assign route_raw[1] = mux_cfg_reg[`CWM_MUX_NRT_HI:`CWM_MUX_NRT_LO];

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_route
      assign route_eff[gi] = (route_raw[gi][1] && !cal_source_enable)
                             ? 2'h0 // RL13
                             : route_raw[gi]; // RL12 RL14
    end
  endgenerate

  // Polarity, input switches and routes toward the input multiplexers, one driver
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      mux_out.invert      <= 1'b0;
      mux_out.pos_connect <= 1'b0;
      mux_out.neg_connect <= 1'b0;
      mux_out.pos_route <= cwm_pkg::CWM_ROUTE_NONE;
      mux_out.neg_route <= cwm_pkg::CWM_ROUTE_NONE;
    end else begin
      mux_out.invert      <= mux_cfg_reg[`CWM_MUX_INV_BIT]; // RL9
      mux_out.pos_connect <= ~mux_cfg_reg[`CWM_MUX_PISO_BIT]; // RL10
      mux_out.neg_connect <= ~mux_cfg_reg[`CWM_MUX_NISO_BIT]; // RL11
      mux_out.pos_route <= cwm_pkg::cwm_route_t'(route_eff[0]); // RL12
      mux_out.neg_route <= cwm_pkg::cwm_route_t'(route_eff[1]); // RL12
    end
  end

endmodule : cwm_top

/* File: sim/cwm_chk.sv */
// Concurrent checks on the calibration wave and input mux ports
`timescale 1ns/100ps
`include "cwm_regs.svh"
module cwm_chk (
  input wire logic                   clock,
  input wire logic                   rst_b,
  input wire logic [`CWM_ADDR_W-1:0] reg_addr,
  input wire logic [`CWM_DATA_W-1:0] reg_wdata,
  input wire logic                   reg_wr,
  input wire logic                   reg_rd,
  input wire logic [`CWM_DATA_W-1:0] reg_rdata,
  input wire logic [1:0]             master_freq_select,
  input wire logic                   master_tick,
  input wire cwm_pkg::cwm_cal_out_t  cal_out,
  input wire cwm_pkg::cwm_mux_out_t  mux_out
);
  // Write decodes of the two registers
  wire wr_cal = reg_wr && reg_addr == `CWM_ADDR_CAL;
  wire wr_mux = reg_wr && reg_addr == `CWM_ADDR_EMUX;
  logic [11:0] gap_reg;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);
  // Clocks since the last master tick
  always_ff @(posedge clock or negedge rst_b)
    if (!rst_b) gap_reg <= 12'h0;
    else gap_reg <= master_tick ? 12'h0 : gap_reg + 12'h1;
  // Register read back, enable gating, write-to-output latency and master tick spacing
  property p_cal_back;
    wr_cal ##1 reg_rd && reg_addr == `CWM_ADDR_CAL
      |=> reg_rdata == ($past(reg_wdata, 2) & `CWM_CAL_MASK);
  endproperty
  a_cal_back: assert property (p_cal_back) else $error("cal read back wrong");
  property p_off_quiet; !cal_out.enable |-> cal_out[2:0] == 3'h0; endproperty
  a_off_quiet: assert property (p_off_quiet) else $error("disabled source active");
  property p_cal_cfg;
    wr_cal |-> ##2 cal_out[3:1] == ($past(reg_wdata[22:20], 2) & {3{$past(reg_wdata[22], 2)}});
  endproperty
  a_cal_cfg: assert property (p_cal_cfg) else $error("cal levels wrong");
  property p_mux_cfg;
    wr_mux |-> ##2 mux_out[6:4] == {$past(reg_wdata[23], 2), ~$past(reg_wdata[21:20], 2)};
  endproperty
  a_mux_cfg: assert property (p_mux_cfg) else $error("mux levels wrong");
  property p_mid_route;
    wr_mux && reg_wdata[19:18] == 2'h1 |-> ##2 mux_out.pos_route == cwm_pkg::CWM_ROUTE_MID;
  endproperty
  a_mid_route: assert property (p_mid_route) else $error("mid route missing");
  property p_gate;
    (wr_cal && !reg_wdata[22]) ##1 (!reg_wr) [*3] |-> !mux_out.pos_route[1] && !mux_out.neg_route[1];
  endproperty
  a_gate: assert property (p_gate) else $error("source routed while disabled");
  property p_tick_gap; master_tick |-> gap_reg > 12'h5d0; endproperty
  a_tick_gap: assert property (p_tick_gap) else $error("master tick early");
  property p_tick_due; gap_reg < 12'h640; endproperty
  a_tick_due: assert property (p_tick_due) else $error("master tick late");
endmodule : cwm_chk

bind cwm_top cwm_chk cwm_chk_inst (.clock, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
  .reg_rdata, .master_freq_select, .master_tick, .cal_out, .mux_out);

/* File: sim/tb.sv */
// Self-checking bench for the calibration wave and input mux block
`timescale 1ns/100ps
`include "cwm_regs.svh"
module tb;
  logic                  clock, rst_b, reg_wr, reg_rd, master_tick, hi_all, hi_any;
  logic [7:0]            reg_addr;
  logic [23:0]           reg_wdata, reg_rdata;
  logic [1:0]            master_freq_select;
  cwm_pkg::cwm_cal_out_t cal_out;
  cwm_pkg::cwm_mux_out_t mux_out;
  int                    n_mismatch, n_tests, gap, i;
  logic [65:0]           row;
  logic [15:0]           gaps [4] = '{16'h5f6, 16'h61b, 16'h61b, 16'h61c};
  // Address, write data, read back, cal levels, mux levels
  logic [65:0]           rows [8] = '{
    {8'h12, 24'h7fffff, 24'h707fff, 3'h7, 7'h00}, {8'h14, 24'hffffff, 24'hbf0000, 3'h7, 7'h4f},
    {8'h14, 24'h0e0000, 24'h0e0000, 3'h7, 7'h3e}, {8'h12, 24'h104000, 24'h104000, 3'h0, 7'h30},
    {8'h14, 24'h250000, 24'h250000, 3'h0, 7'h15}, {8'h12, 24'h600000, 24'h600000, 3'h6, 7'h15},
    {8'h12, 24'h500000, 24'h500000, 3'h5, 7'h15}, {8'h13, 24'hffffff, 24'h000000, 3'h5, 7'h15}};

  cwm_top cwm_top_inst (.clock, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .master_freq_select, .master_tick, .cal_out, .mux_out);

  // Free-running 50 MHz clock
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  task automatic chk(string n, logic [23:0] e, logic [23:0] s);
    n_tests++;
    if (s !== e) begin
      $display("Error %s expected %h seen %h", n, e, s);
      n_mismatch++;
    end
  endtask : chk

  task automatic final_report;
    $display("Comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : final_report

  // One bus cycle; a read after a write follows with no gap
  task automatic put(logic w, logic [7:0] a, logic [23:0] d);
    @(posedge clock);
    reg_wr    <= w;
    reg_rd    <= !w;
    reg_addr  <= a;
    reg_wdata <= d;
  endtask : put

  task automatic rdchk(logic [7:0] a, logic [23:0] e);
    put(1'b0, a, 24'h0);
    @(posedge clock);
    {reg_wr, reg_rd} <= 2'h0;
    #1 chk("read data", e, reg_rdata);
  endtask : rdchk

  task automatic wrd(logic [7:0] a, logic [23:0] d, logic [23:0] e);
    put(1'b1, a, d);
    rdchk(a, e);
  endtask : wrd

  // Waits n master ticks, tracking the phase level and the last tick gap
  task automatic ticks(int n);
    int k, g;
    repeat (3) @(posedge clock);
    #1 {hi_all, hi_any} = 2'h2;
    for (k = 0; k < n; k++) begin
      for (g = 0; g < 4000 && master_tick !== 1'b1; g++) begin
        hi_all &= cal_out.phase_high;
        hi_any |= cal_out.phase_high;
        @(posedge clock);
        #1;
      end
      if (g == 4000) begin
        n_mismatch++;
        final_report;
      end
      gap = g;
      @(posedge clock);
      #1;
    end
  endtask : ticks

  // Main sequence
  initial begin
    {rst_b, reg_wr, reg_rd, reg_addr, reg_wdata, master_freq_select} = '0;
    repeat (6) @(posedge clock);
    rst_b <= 1'b1;
    foreach (rows[j]) begin
      row = rows[j];
      wrd(row[65:58], row[57:34], row[33:10]);
      repeat (3) @(posedge clock);
      #1 chk("cal levels", 24'(row[9:7]), 24'(cal_out[3:1]));
      chk("mux levels", 24'(row[6:0]), 24'(mux_out));
    end
    $display("Test table done");
    @(posedge clock) rst_b <= 1'b0;
    @(posedge clock);
    #1 chk("reset levels", 24'h0, 24'({cal_out, mux_out}));
    rst_b <= 1'b1;
    rdchk(8'h12, 24'h004800);
    rdchk(8'h14, 24'h300000);
    $display("Test reset done");
    wrd(8'h12, 24'h400003, 24'h400003);
    repeat (3) @(posedge clock);
    #1 gap = 0;
    for (i = 0; i < 20000 && cal_out.phase_high === 1'b1; i++) begin
      gap += (master_tick === 1'b1);
      @(posedge clock);
      #1;
    end
    chk("high ticks", 24'h3, 24'(gap));
    wrd(8'h12, 24'h400000, 24'h400000);
    ticks(4);
    chk("never high", 24'h0, 24'(hi_any));
    wrd(8'h12, 24'h400802, 24'h400802);
    ticks(5);
    chk("half high", 24'h1, 24'(hi_all));
    $display("Test waveform done");
    for (i = 0; i < 4; i++) begin
      @(posedge clock) master_freq_select <= 2'(i);
      ticks(2);
      chk("tick gap", 24'h1, 24'(gap + 3 - gaps[i] <= 4));
    end
    $display("Test master clock done");
    final_report;
  end
endmodule : tb
